// ### src/sample_hold_adc_control.sv
// Sample and hold control: registers, triggers, slots, results, discharge
//
// Design decisions made here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "sample_hold_regs.svh"
module sample_hold_adc_control
    import sample_hold_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic trigger_input_0,
    input wire logic trigger_input_1,
    input wire logic external_clock_input,
    output conv_req_type conv_req,
    input wire logic conv_done,
    input wire logic [13:0] conv_data,
    output logic hold_priority_high,
    output buf_write_type buf_write,
    output logic hold0_discharge,
    output logic hold1_discharge,
    output logic hold0_done_irq,
    output logic hold1_done_irq
);
    ////////////////////////////////////////////////////////////////////////
    logic [15:0] ctrl;
    logic [15:0] next_ctrl;
    logic [31:0] next_dat;
    logic next_ack;
    logic [15:0] status;
    logic wr_hit;
    logic dual;
    logic fast;
    logic ext_q;
    logic ext_tick;
    logic trig1_route;
    logic h0_sampling;
    logic h1_sampling;
    logic h0_end;
    logic h1_end;

    assign dual = ctrl[`DUAL_BIT];
    assign fast = ctrl[`FAST_BIT];
    assign wr_hit = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i &&
        wb_adr_i == `CTRL_OFFSET;

    always_comb begin
        next_ctrl = ctrl;
        next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
        next_dat = 32'h0000_0000;
        // Bit 7 never stores, so a stray one cannot steer anything
        if (wr_hit && wb_sel_i[0]) begin
            next_ctrl[7:0] = wb_dat_i[7:0] & 8'(`CTRL_WMASK);
        end
        if (wr_hit && wb_sel_i[1]) begin
            next_ctrl[15:8] = wb_dat_i[15:8];
        end
        if (next_ack && !wb_we_i) begin
            case (wb_adr_i)
                `CTRL_OFFSET: next_dat = {16'h0000, ctrl};
                `STATUS_OFFSET: next_dat = {16'h0000, status};
                default: next_dat = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl <= `CTRL_RESET;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            ext_q <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
            ext_q <= external_clock_input;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign ext_tick = external_clock_input && !ext_q;
    assign trig1_route = dual ? trigger_input_1 : trigger_input_0;

    sample_window_timer u_win0 (
        .clk(clk),
        .srst(srst),
        .arm(ctrl[`HOLD0_ENABLE_BIT]),
        .trig(trigger_input_0),
        .ext_tick(ext_tick),
        .clk_sel(ctrl[`CLK_SEL_BIT]),
        .code(ctrl[`SSC_LSB +: 4]),
        .sampling(h0_sampling),
        .done(h0_end)
    );

    sample_window_timer u_win1 (
        .clk(clk),
        .srst(srst),
        .arm(ctrl[`HOLD1_ENABLE_BIT]),
        .trig(trig1_route),
        .ext_tick(ext_tick),
        .clk_sel(ctrl[`CLK_SEL_BIT]),
        .code(ctrl[`SSC_LSB +: 4]),
        .sampling(h1_sampling),
        .done(h1_end)
    );

    ////////////////////////////////////////////////////////////////////////
    sched_state_type state;
    sched_state_type next_state;
    logic [11:0] slot_cnt;
    logic [11:0] next_slot_cnt;
    logic phase;
    logic next_phase;
    logic tick;
    logic g0, g1, next_g0, next_g1;
    logic pend0, pend1, next_pend0, next_pend1;
    logic cur_hold, next_cur_hold;
    logic next_start;
    logic [15:0] word;
    buf_write_type next_buf;
    logic next_irq0, next_irq1;
    logic [3:0] dis0_cnt, dis1_cnt, next_dis0, next_dis1;

    assign tick = slot_cnt == 12'(`SLOT_FAST_CYC - 1);
    assign hold_priority_high = fast && ctrl[`HOLD0_ENABLE_BIT];
    assign status = {9'h000, hold1_discharge, hold0_discharge,
        state == ST_CONV, pend1, pend0, h1_sampling,
        h0_sampling};

    result_formatter u_fmt (
        .raw(conv_data),
        .left_align(cur_hold ? ctrl[`HOLD1_ALIGN_BIT]
                             : ctrl[`HOLD0_ALIGN_BIT]),
        .word(word)
    );

    always_comb begin
        next_slot_cnt = tick ? 12'h000 : slot_cnt + 12'h001;
        next_phase = tick ? ~phase : phase;
        next_g0 = g0;
        next_g1 = g1;
        next_pend0 = pend0;
        next_pend1 = pend1;
        next_state = state;
        next_cur_hold = cur_hold;
        next_start = 1'b0;
        next_buf = '0;
        next_irq0 = 1'b0;
        next_irq1 = 1'b0;
        next_dis0 = dis0_cnt == 4'h0 ? 4'h0 : dis0_cnt - 4'h1;
        next_dis1 = dis1_cnt == 4'h0 ? 4'h0 : dis1_cnt - 4'h1;
        case (state)
            ST_IDLE: begin
                if (pend0 && g0) begin
                    next_g0 = 1'b0;
                    next_pend0 = 1'b0;
                    next_cur_hold = 1'b0;
                    next_start = 1'b1;
                    next_state = ST_CONV;
                end else if (pend1 && g1 && dual) begin
                    next_g1 = 1'b0;
                    next_pend1 = 1'b0;
                    next_cur_hold = 1'b1;
                    next_start = 1'b1;
                    next_state = ST_CONV;
                end
            end
            ST_CONV: begin
                if (conv_done) begin
                    next_buf.en = 1'b1;
                    next_buf.data = word;
                    next_state = ST_IDLE;
                    if (!cur_hold) begin
                        next_buf.addr = `HOLD0_BUF_LOC;
                        if (ctrl[`HOLD0_DISCH_BIT]) begin
                            next_dis0 = 4'(`DISCHARGE_CYC);
                        end
                        if (!dual && pend1) begin
                            // Single mode: hold 1 rides on the same slot
                            next_pend1 = 1'b0;
                            next_cur_hold = 1'b1;
                            next_start = 1'b1;
                            next_state = ST_CONV;
                        end else begin
                            next_irq0 = ctrl[`HOLD0_IRQ_EN_BIT];
                        end
                    end else begin
                        next_buf.addr = `HOLD1_BUF_LOC;
                        if (ctrl[`HOLD1_DISCH_BIT]) begin
                            next_dis1 = 4'(`DISCHARGE_CYC);
                        end
                        next_irq1 = dual && ctrl[`HOLD1_IRQ_EN_BIT];
                        next_irq0 = !dual && ctrl[`HOLD0_IRQ_EN_BIT];
                    end
                end
            end
            default: next_state = ST_IDLE;
        endcase
        // Grants are set after use so a new slot is never lost
        if (tick && (fast || phase)) begin
            next_g0 = 1'b1;
        end
        if (tick && phase) begin
            next_g1 = 1'b1;
        end
        if (h0_end) begin
            next_pend0 = 1'b1;
        end
        if (h1_end) begin
            next_pend1 = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= ST_IDLE;
            slot_cnt <= 12'h000;
            phase <= 1'b0;
            g0 <= 1'b0;
            g1 <= 1'b0;
            pend0 <= 1'b0;
            pend1 <= 1'b0;
            cur_hold <= 1'b0;
            conv_req <= '0;
            buf_write <= '0;
            hold0_done_irq <= 1'b0;
            hold1_done_irq <= 1'b0;
            dis0_cnt <= 4'h0;
            dis1_cnt <= 4'h0;
        end else begin
            state <= next_state;
            slot_cnt <= next_slot_cnt;
            phase <= next_phase;
            g0 <= next_g0;
            g1 <= next_g1;
            pend0 <= next_pend0;
            pend1 <= next_pend1;
            cur_hold <= next_cur_hold;
            conv_req <= {next_start, next_cur_hold};
            buf_write <= next_buf;
            hold0_done_irq <= next_irq0;
            hold1_done_irq <= next_irq1;
            dis0_cnt <= next_dis0;
            dis1_cnt <= next_dis1;
        end
    end

    assign hold0_discharge = dis0_cnt != 4'h0;
    assign hold1_discharge = dis1_cnt != 4'h0;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_fast_grant: assert property (tick && fast |=> g0)
        else $error("fast slot did not grant hold 0");
    a_normal_grant: assert property (
        tick && !fast && !phase && !g0 |=> !g0)
        else $error("hold 0 granted off its normal slot");
    a_disch1_len: assert property (
        state == ST_CONV && conv_done && cur_hold && ctrl[`HOLD1_DISCH_BIT]
        |=> hold1_discharge [*8])
        else $error("hold 1 discharge too short");
    a_disch0_len: assert property (
        state == ST_CONV && conv_done && !cur_hold && ctrl[`HOLD0_DISCH_BIT]
        |=> hold0_discharge [*8])
        else $error("hold 0 discharge too short");
    a_dual_split: assert property (
        dual && !h0_sampling && !trigger_input_0 && $rose(trigger_input_1)
        |=> !h0_sampling)
        else $error("trigger 1 started hold 0");
    a_single_both: assert property (
        !dual && ctrl[`HOLD1_ENABLE_BIT] && !h1_sampling &&
        $rose(trigger_input_0) |=> h1_sampling)
        else $error("trigger 0 did not start hold 1");
    a_h1_format: assert property (
        buf_write.en && buf_write.addr == `HOLD1_BUF_LOC &&
        $past(ctrl[`HOLD1_ALIGN_BIT]) |-> buf_write.data[1:0] == 2'b00)
        else $error("hold 1 left format not padded");
    a_h0_format: assert property (
        buf_write.en && buf_write.addr == `HOLD0_BUF_LOC &&
        !$past(ctrl[`HOLD0_ALIGN_BIT]) |->
        buf_write.data[15:14] == {2{buf_write.data[13]}})
        else $error("hold 0 right format not sign extended");
    a_irq1_dual: assert property (
        hold1_done_irq |-> $past(dual && ctrl[`HOLD1_IRQ_EN_BIT]))
        else $error("hold 1 interrupt outside dual mode");
    a_irq0_single: assert property (
        hold0_done_irq && $past(!dual && ctrl[`HOLD1_ENABLE_BIT]) |->
        $past(cur_hold))
        else $error("single mode hold 0 done before hold 1");
    a_buf_loc: assert property (
        buf_write.en |-> buf_write.addr ==
        ($past(cur_hold) ? `HOLD1_BUF_LOC : `HOLD0_BUF_LOC))
        else $error("result written to wrong location");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    c_fast_conv: cover property (fast && conv_req.start && !conv_req.hold);
    c_single_irq: cover property (!dual && hold0_done_irq);
    c_dual_irq1: cover property (dual && hold1_done_irq);
endmodule
`default_nettype wire

// ### src/sample_hold_regs.svh
// Register offsets, field positions and timing counts for the hold control
`ifndef SAMPLE_HOLD_REGS_SVH
`define SAMPLE_HOLD_REGS_SVH

`define CTRL_OFFSET 8'h00
`define STATUS_OFFSET 8'h04
`define CTRL_RESET 16'h0000
`define CTRL_WMASK 16'hff7f

`define HOLD0_ENABLE_BIT 0
`define HOLD0_IRQ_EN_BIT 1
`define HOLD0_ALIGN_BIT 2
`define CLK_SEL_BIT 3
`define HOLD1_ENABLE_BIT 4
`define HOLD1_IRQ_EN_BIT 5
`define HOLD1_ALIGN_BIT 6
`define DUAL_BIT 8
`define HOLD0_DISCH_BIT 9
`define HOLD1_DISCH_BIT 10
`define FAST_BIT 11
`define SSC_LSB 12

`define HOLD0_BUF_LOC 5'h17
`define HOLD1_BUF_LOC 5'h18

`define CLK_NS 50
`define NS_TO_CYC(n) (((n) + `CLK_NS - 1) / `CLK_NS)
`define SLOT_FAST_US 125
`define SLOT_NORMAL_US 250
`define SLOT_FAST_CYC ((`SLOT_FAST_US * 1000) / `CLK_NS)
`define SLOT_RATIO (`SLOT_NORMAL_US / `SLOT_FAST_US)
`define DISCHARGE_NS 500
`define DISCHARGE_CYC `NS_TO_CYC(`DISCHARGE_NS)
`define EXT_CLK_BASE 20
`define SSC_FIRST_TIMED 4
`define SSC_NS_4 300
`define SSC_NS_5 350
`define SSC_NS_6 450
`define SSC_NS_7 550
`define SSC_NS_8 750
`define SSC_NS_9 1000
`define SSC_NS_10 1500
`define SSC_NS_11 1750
`define SSC_NS_12 2000
`define SSC_NS_13 2500
`define SSC_NS_14 4000
`define SSC_NS_15 5000

`endif

// ### src/sample_hold_pkg.sv
// Types shared by the sample and hold control files
package sample_hold_pkg;

typedef struct packed {
    logic en;
    logic [4:0] addr;
    logic [15:0] data;
} buf_write_type;

typedef struct packed {
    logic start;
    logic hold;
} conv_req_type;

typedef enum logic {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
} sched_state_type;

endpackage

// ### src/result_formatter.sv
// Places a 14-bit conversion result in the 16-bit result word
`timescale 1ns/100ps
`default_nettype none
module result_formatter (
    input wire logic [13:0] raw,
    input wire logic left_align,
    output logic [15:0] word
);
    always_comb begin
        if (left_align) begin
            word = {raw, 2'b00};
        end else begin
            word = {{2{raw[13]}}, raw};
        end
    end
endmodule
`default_nettype wire

// ### src/sample_window_timer.sv
// Sampling window of one hold: opens on trigger rise, closes by code
`timescale 1ns/100ps
`default_nettype none
`include "sample_hold_regs.svh"
module sample_window_timer (
    input wire logic clk,
    input wire logic srst,
    input wire logic arm,
    input wire logic trig,
    input wire logic ext_tick,
    input wire logic clk_sel,
    input wire logic [3:0] code,
    output logic sampling,
    output logic done
);
    logic trig_q;
    logic [6:0] cnt;
    logic next_sampling;
    logic next_done;
    logic [6:0] next_cnt;
    logic edge_mode;
    logic step;

    function automatic logic [6:0] delay_cycles(input logic [3:0] c);
        case (c)
            4'h4: delay_cycles = 7'(`NS_TO_CYC(`SSC_NS_4));
            4'h5: delay_cycles = 7'(`NS_TO_CYC(`SSC_NS_5));
            4'h6: delay_cycles = 7'(`NS_TO_CYC(`SSC_NS_6));
            4'h7: delay_cycles = 7'(`NS_TO_CYC(`SSC_NS_7));
            4'h8: delay_cycles = 7'(`NS_TO_CYC(`SSC_NS_8));
            4'h9: delay_cycles = 7'(`NS_TO_CYC(`SSC_NS_9));
            4'ha: delay_cycles = 7'(`NS_TO_CYC(`SSC_NS_10));
            4'hb: delay_cycles = 7'(`NS_TO_CYC(`SSC_NS_11));
            4'hc: delay_cycles = 7'(`NS_TO_CYC(`SSC_NS_12));
            4'hd: delay_cycles = 7'(`NS_TO_CYC(`SSC_NS_13));
            4'he: delay_cycles = 7'(`NS_TO_CYC(`SSC_NS_14));
            default: delay_cycles = 7'(`NS_TO_CYC(`SSC_NS_15));
        endcase
    endfunction

    // Reserved codes on the peripheral clock fall back to edge mode
    assign edge_mode = (code == 4'h0) ||
        (!clk_sel && code < 4'(`SSC_FIRST_TIMED));
    assign step = clk_sel ? ext_tick : 1'b1;

    always_comb begin
        next_sampling = sampling;
        next_cnt = cnt;
        next_done = 1'b0;
        if (!sampling) begin
            if (arm && trig && !trig_q) begin
                next_sampling = 1'b1;
                next_cnt = 7'h00;
            end
        end else if (edge_mode) begin
            if (!trig) begin
                next_sampling = 1'b0;
                next_done = 1'b1;
            end
        end else if (step) begin
            next_cnt = cnt + 7'h01;
            if (clk_sel ? (cnt + 7'h01 >= 7'(`EXT_CLK_BASE) + 7'(code))
                        : (cnt + 7'h01 >= delay_cycles(code))) begin
                next_sampling = 1'b0;
                next_done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            trig_q <= 1'b0;
            sampling <= 1'b0;
            done <= 1'b0;
            cnt <= 7'h00;
        end else begin
            trig_q <= trig;
            sampling <= next_sampling;
            done <= next_done;
            cnt <= next_cnt;
        end
    end
endmodule
`default_nettype wire

// ### verif/trigger_converter_model.sv
// Far side model: trigger pins, external clock and converter
`timescale 1ns/100ps
`default_nettype none
module trigger_converter_model
    import sample_hold_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [1:0] fire,
    input wire logic [15:0] width,
    input wire logic [7:0] latency,
    input wire logic [13:0] sample0,
    input wire logic [13:0] sample1,
    input wire conv_req_type conv_req,
    output logic trigger_input_0,
    output logic trigger_input_1,
    output logic external_clock_input,
    output logic conv_done,
    output logic [13:0] conv_data
);
////////////////////////////////////////////////////////////
logic [15:0] left0, left1;
logic [7:0] wait_cnt;
logic [1:0] div;
logic [13:0] junk;
logic busy, held;
assign trigger_input_0 = left0 != 16'h0000;
assign trigger_input_1 = left1 != 16'h0000;
// Moving pattern outside done, so stale data never looks valid
assign conv_data = conv_done ? (held ? sample1 : sample0) : junk;
// Clock input runs free: a timed delay may start mid period
always_ff @(posedge clk) begin
    if (srst) begin
        left0 <= 16'h0000;
        left1 <= 16'h0000;
        div <= 2'h0;
        junk <= 14'h0000;
        busy <= 1'b0;
        held <= 1'b0;
        wait_cnt <= 8'h00;
        conv_done <= 1'b0;
        external_clock_input <= 1'b0;
    end else begin
        junk <= junk + 14'h1555;
        div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
        if (div == 2'h2) begin
            external_clock_input <= !external_clock_input;
        end
        left0 <= fire[0] ? width : (left0 != 0 ? left0 - 16'h0001 : left0);
        left1 <= fire[1] ? width : (left1 != 0 ? left1 - 16'h0001 : left1);
        conv_done <= 1'b0;
        if (conv_req.start) begin
            busy <= 1'b1;
            held <= conv_req.hold;
            wait_cnt <= latency;
        end else if (busy && wait_cnt == 8'h00) begin
            conv_done <= 1'b1;
            busy <= 1'b0;
        end else if (busy) begin
            wait_cnt <= wait_cnt - 8'h01;
        end
    end
end
endmodule
`default_nettype wire

// ### verif/sample_hold_adc_control_tb.sv
// Self-checking bench for the sample and hold control block
`timescale 1ns/100ps
`default_nettype none
module sample_hold_adc_control_tb;
import sample_hold_pkg::*;
logic clk = 1'b0;
logic srst = 1'b1;
logic [7:0] wb_adr_i = 8'h00;
logic [31:0] wb_dat_i = 32'h0000_0000;
logic [31:0] wb_dat_o, q;
logic wb_we_i = 1'b0;
logic [3:0] wb_sel_i = 4'h0;
logic wb_cyc_i = 1'b0;
logic wb_stb_i = 1'b0;
logic wb_ack_o, trigger_input_0, trigger_input_1, external_clock_input;
conv_req_type conv_req;
buf_write_type buf_write;
logic conv_done, hold_priority_high, hold0_discharge, hold1_discharge;
logic [13:0] conv_data;
logic hold0_done_irq, hold1_done_irq;
logic [1:0] fire = 2'b00;
logic [15:0] width = 16'h0002;
logic [7:0] lat = 8'h03;
logic [13:0] sample0 = 14'h0000;
logic [13:0] sample1 = 14'h0000;
int fails = 0, checked = 0, cyc_n = 0;
int dis0_len = 0, dis1_len = 0, dis0_run = 0, dis1_run = 0;
logic [23:0] wq[$];
int sq[$];
logic [15:0] ctl[3] = '{16'hf101, 16'hf109, 16'h0101};
int wid[3] = '{2, 2, 150};
int p1[3] = '{80, 120, 120};
int p2[3] = '{40, 120, 50};

always #25 clk = !clk;

sample_hold_adc_control i_sample_hold_adc_control (.clk, .srst, .wb_adr_i,
    .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i,
    .wb_ack_o, .trigger_input_0, .trigger_input_1, .external_clock_input,
    .conv_req, .conv_done, .conv_data, .hold_priority_high, .buf_write,
    .hold0_discharge, .hold1_discharge, .hold0_done_irq, .hold1_done_irq);
trigger_converter_model i_trigger_converter_model (.clk, .srst, .fire,
    .width, .latency(lat), .sample0, .sample1, .conv_req, .trigger_input_0,
    .trigger_input_1, .external_clock_input, .conv_done, .conv_data);
////////////////////////////////////////////////////////////
task automatic bad(input string m);
    fails++;
    $display("unexpected at %0t: %s", $time, m);
endtask
task automatic chk_val(input logic [31:0] got, exp, input string m);
    checked++;
    if (got !== exp) bad($sformatf("%s got %h want %h", m, got, exp));
endtask
task automatic chk_cnt(input int got, exp, input string m);
    checked++;
    if (got != exp) bad($sformatf("%s got %0d want %0d", m, got, exp));
endtask
task automatic bus(input logic [7:0] a, input logic w, input logic [15:0] d);
    @(posedge clk);
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= {16'h0000, d};
    wb_sel_i <= 4'h3;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin
        @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
endtask
task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
    bus(a, 1'b0, 16'h0000);
    chk_val(q, e, m);
endtask
task automatic trig(input logic [1:0] f, input logic [15:0] w);
    @(posedge clk);
    width <= w;
    fire <= f;
    @(posedge clk);
    fire <= 2'b00;
endtask
task automatic wait_w(input int n);
    int k;
    k = 0;
    while (wq.size() < n && k < 12000) begin
        @(posedge clk);
        k++;
    end
    if (wq.size() < n) bad("no result");
endtask
task automatic chk_w(input int i, input logic [23:0] e, input string m);
    chk_val({8'h00, wq[i]}, {8'h00, e}, m);
endtask
task automatic give_verdict;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
        $display("[ PASS ]");
    end else begin
        $display("[ FAIL ]");
    end
    $finish;
endtask
////////////////////////////////////////////////////////////
always @(posedge clk) begin
    cyc_n++;
    if (conv_req.start === 1'b1) sq.push_back(cyc_n);
    if (buf_write.en === 1'b1) begin
        wq.push_back({hold0_done_irq, hold1_done_irq, 1'b0, buf_write.addr,
            buf_write.data});
    end else if ((hold0_done_irq | hold1_done_irq) === 1'b1) begin
        bad("irq without result");
    end
    if (hold0_discharge === 1'b1) begin
        dis0_run++;
    end else if (dis0_run != 0) begin
        dis0_len = dis0_run;
        dis0_run = 0;
    end
    if (hold1_discharge === 1'b1) begin
        dis1_run++;
    end else if (dis1_run != 0) begin
        dis1_len = dis1_run;
        dis1_run = 0;
    end
end

initial begin
    repeat (95000) @(posedge clk);
    bad("watchdog");
    give_verdict();
end

initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rd(8'h00, 32'h0000_0000, "ctrl reset");
    rd(8'h04, 32'h0000_0000, "status reset");
    bus(8'h00, 1'b1, 16'hff7f);
    rd(8'h00, 32'h0000_ff7f, "ctrl all bits");
    chk_val(32'(hold_priority_high), 32'h0000_0001, "priority");
    bus(8'h00, 1'b1, 16'h0000);
    bus(8'h04, 1'b1, 16'hffff);
    bus(8'h08, 1'b1, 16'hffff);
    rd(8'h04, 32'h0000_0000, "status write");
    rd(8'h08, 32'h0000_0000, "unmapped");
    chk_val(32'(hold_priority_high), 32'h0000_0000, "priority");
    $display("test registers done");
    sample0 <= 14'h2a5c;
    sample1 <= 14'h2001;
    bus(8'h00, 1'b1, 16'h0737);
    trig(2'b01, 16'h0002);
    wait_w(1);
    chk_w(0, {2'b10, 1'b0, 5'h17, sample0, 2'b00}, "h0");
    repeat (5100) @(posedge clk);
    chk_cnt(wq.size(), 1, "trigger 0 only");
    chk_cnt(dis0_len, 10, "discharge 0");
    trig(2'b10, 16'h0002);
    wait_w(2);
    chk_w(1, {3'b010, 5'h18, {2{sample1[13]}}, sample1}, "h1");
    repeat (20) @(posedge clk);
    chk_cnt(dis1_len, 10, "discharge 1");
    $display("test dual done");
    wq.delete();
    lat <= 8'h28;
    sample0 <= 14'h1234;
    sample1 <= 14'h3fff;
    bus(8'h00, 1'b1, 16'h0073);
    trig(2'b10, 16'h0002);
    repeat (5100) @(posedge clk);
    chk_cnt(wq.size(), 0, "trigger 1 ignored");
    trig(2'b01, 16'h0002);
    wait_w(2);
    chk_w(0, {3'b000, 5'h17, {2{sample0[13]}}, sample0}, "s0");
    chk_w(1, {3'b100, 5'h18, sample1, 2'b00}, "s1");
    $display("test single done");
    lat <= 8'h03;
    for (int m = 0; m < 2; m++) begin
        bus(8'h00, 1'b1, m == 0 ? 16'h0901 : 16'h0101);
        repeat (2) @(posedge clk);
        chk_val(32'(hold_priority_high), 32'(m == 0), "prio");
        sq.delete();
        wq.delete();
        for (int k = 1; k <= 3; k++) begin
            trig(2'b01, 16'h0002);
            wait_w(k);
        end
        chk_cnt(sq[2] - sq[1], m == 0 ? 2500 : 5000, "slot");
    end
    $display("test slots done");
    // Each case waits for its result so a late one cannot land in the next case's queue
    for (int i = 0; i < 3; i++) begin
        wq.delete();
        bus(8'h00, 1'b1, ctl[i]);
        trig(2'b01, 16'(wid[i]));
        repeat (p1[i]) @(posedge clk);
        bus(8'h04, 1'b0, 16'h0000);
        chk_val(32'(q[0]), 32'h0000_0001, "sampling");
        repeat (p2[i]) @(posedge clk);
        bus(8'h04, 1'b0, 16'h0000);
        chk_val(32'(q[0]), 32'h0000_0000, "stopped");
        wait_w(1);
    end
    $display("test windows done");
    give_verdict();
end
endmodule
`default_nettype wire
